//--- design/asb_pkg.sv
package asb_pkg;
  localparam int unsigned DataW = 16;
  localparam int unsigned AccW = 40;
  localparam int unsigned AddrW = 4;
  // register indices on the plain register port
  localparam logic [AddrW-1:0] RegOpA = 4'h0;
  localparam logic [AddrW-1:0] RegOpB = 4'h1;
  localparam logic [AddrW-1:0] RegCmd = 4'h2;
  localparam logic [AddrW-1:0] RegResult = 4'h3;
  localparam logic [AddrW-1:0] RegStatus = 4'h4;
  localparam logic [AddrW-1:0] RegAccAL = 4'h5;
  localparam logic [AddrW-1:0] RegAccBL = 4'h6;
  localparam logic [AddrW-1:0] RegCycles = 4'h7;
  localparam logic [AddrW-1:0] RegBusy = 4'h8;
  localparam logic [AddrW-1:0] RegAccAH = 4'h9;
  localparam logic [AddrW-1:0] RegAccBH = 4'hA;
  // command word fields
  localparam int unsigned CmdOpLsb = 0;
  localparam int unsigned CmdOpW = 4;
  localparam int unsigned CmdCondLsb = 4;
  localparam int unsigned CmdCondW = 5;
  localparam int unsigned CmdAccSel = 9;
  localparam int unsigned CmdZSel = 10;
  localparam int unsigned CmdExtSfr = 11;
  localparam int unsigned CmdAccPresent = 12;
  // status bit positions
  localparam int unsigned StC = 0;
  localparam int unsigned StZ = 1;
  localparam int unsigned StOv = 2;
  localparam int unsigned StN = 3;
  localparam int unsigned StDc = 4;
  localparam int unsigned StOa = 5;
  localparam int unsigned StOb = 6;
  localparam int unsigned StSa = 7;
  localparam int unsigned StSb = 8;
  localparam int unsigned StatusW = 9;
  localparam logic [StatusW-1:0] StatusReset = 9'h000;
  // cycle counts
  localparam logic [2:0] CyclesBase = 3'h1;
  localparam logic [2:0] CyclesTaken = 3'h4;
  localparam logic [2:0] CyclesSfrExtra = 3'h1;
  localparam int unsigned Lit10W = 10;
  localparam int unsigned Lit5W = 5;
  localparam int unsigned ShiftLitW = 4;
  localparam int unsigned DigitMsb = 3;
  localparam int unsigned ShAmtW = 4;

  typedef enum logic [3:0] {
    OpAdd = 4'h0,
    OpAddCarry = 4'h1,
    OpAddLit10 = 4'h2,
    OpAddLit10Carry = 4'h3,
    OpAddLit5 = 4'h4,
    OpAddLit5Carry = 4'h5,
    OpAccAdd = 4'h6,
    OpAsr1 = 4'h7,
    OpAsrN = 4'h8,
    OpAsrLit5 = 4'h9,
    OpBranchCond = 4'hA,
    OpBranch = 4'hB,
    OpBranchComputed = 4'hC,
    OpFlagToBit = 4'hD,
    OpSfrRead = 4'hE,
    OpNop = 4'hF
  } asb_op_t;

  typedef enum logic [4:0] {
    CondC = 5'h00, CondNc = 5'h01, CondN = 5'h02, CondNn = 5'h03,
    CondOv = 5'h04, CondNov = 5'h05, CondZ = 5'h06, CondNz = 5'h07,
    CondGt = 5'h08, CondGe = 5'h09, CondLt = 5'h0A, CondLe = 5'h0B,
    CondGtu = 5'h0C, CondGeu = 5'h0D, CondLtu = 5'h0E, CondLeu = 5'h0F,
    CondOa = 5'h10, CondOb = 5'h11, CondSa = 5'h12, CondSb = 5'h13
  } asb_cond_t;

  typedef enum logic [1:0] {
    StIdle = 2'b00,
    StWait = 2'b01
  } asb_state_t;
endpackage : asb_pkg

//--- design/asb_cond_eval.sv
`timescale 1ns/1ns
module asb_cond_eval (
  input wire logic [4:0] cond,
  input wire logic [asb_pkg::StatusW-1:0] status,
  input wire logic accPresent,
  output logic taken
);
  wire c = status[asb_pkg::StC];
  wire z = status[asb_pkg::StZ];
  wire v = status[asb_pkg::StOv];
  wire n = status[asb_pkg::StN];
  wire nXorV = n ^ v;
  always_comb begin
    case (cond)
      asb_pkg::CondC: taken = c;
      asb_pkg::CondNc: taken = ~c;
      asb_pkg::CondN: taken = n;
      asb_pkg::CondNn: taken = ~n;
      asb_pkg::CondOv: taken = v;
      asb_pkg::CondNov: taken = ~v;
      asb_pkg::CondZ: taken = z;
      asb_pkg::CondNz: taken = ~z;
      asb_pkg::CondGt: taken = ~z & ~nXorV;
      asb_pkg::CondGe: taken = ~nXorV;
      asb_pkg::CondLt: taken = nXorV;
      asb_pkg::CondLe: taken = z | nXorV;
      asb_pkg::CondGtu: taken = c & ~z;
      asb_pkg::CondGeu: taken = c;
      asb_pkg::CondLtu: taken = ~c;
      asb_pkg::CondLeu: taken = ~c | z;
      // accumulator tests fall through as not taken without the accumulator datapath
      asb_pkg::CondOa: taken = accPresent & status[asb_pkg::StOa];
      asb_pkg::CondOb: taken = accPresent & status[asb_pkg::StOb];
      asb_pkg::CondSa: taken = accPresent & status[asb_pkg::StSa];
      asb_pkg::CondSb: taken = accPresent & status[asb_pkg::StSb];
      default: taken = 1'b0;
    endcase
  end
endmodule : asb_cond_eval

//--- design/asb_adder.sv
`timescale 1ns/1ns
module asb_adder (
  input wire logic [asb_pkg::DataW-1:0] a,
  input wire logic [asb_pkg::DataW-1:0] b,
  input wire logic cin,
  output logic [asb_pkg::DataW-1:0] sum,
  output logic cout,
  output logic dcout,
  output logic ovf
);
  localparam int unsigned W = asb_pkg::DataW;
  localparam int unsigned D = asb_pkg::DigitMsb;
  logic [W:0] full;
  logic [D+1:0] low;
  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign low = {1'b0, a[D:0]} + {1'b0, b[D:0]} + {{(D+1){1'b0}}, cin};
  assign sum = full[W-1:0];
  assign cout = full[W];
  assign dcout = low[D+1];
  assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
endmodule : asb_adder

//--- design/asb_exec_unit.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
// ==========================================
// Contract
// - add two operands, optional carry in; sources include two literals; update C DC N OV Z
// - accumulator add of shifted signed word; only accumulator overflow and saturation flags
// - one-step arithmetic right shift keeps sign; updates C N OV Z
// - multi-step arithmetic right shift by register or literal; updates only N and Z
// - conditional branch 1 cycle, taken 4; other branches 4; no flag changes
// - signed and unsigned comparisons evaluated separately from stored flags
// - branch on carry, negative, overflow, zero, set or clear
// - branch on each accumulator overflow and saturation, only with accumulator datapath
// - copy carry or zero into register bit chosen by another register; flags unchanged
// - access to a special register outside the core adds one cycle
module asb_exec_unit (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [asb_pkg::AddrW-1:0] addr,
  input wire logic [asb_pkg::DataW-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [asb_pkg::DataW-1:0] rdData,
  output logic busy,
  output logic branchTaken
);
  localparam int unsigned W = asb_pkg::DataW;
  localparam int unsigned AW = asb_pkg::AccW;

  // ==========================================
  // registers
  logic [W-1:0] opA_q, opB_q, result_q, result_d;
  logic [asb_pkg::StatusW-1:0] status_q, status_d;
  logic [AW-1:0] accA_q, accB_q, accA_d, accB_d;
  logic [2:0] cycles_q, cycles_d, waitCnt_q, waitCnt_d;
  asb_pkg::asb_state_t state_q, state_d;
  logic [W-1:0] rdData_q;
  logic busy_q, busy_d;
  logic taken_q, taken_d;

  // ==========================================
  // command decode
  wire cmdWrite = wrStrobe && (addr == asb_pkg::RegCmd) && (state_q == asb_pkg::StIdle);
  wire [asb_pkg::CmdOpW-1:0] opField = wrData[asb_pkg::CmdOpLsb +: asb_pkg::CmdOpW];
  wire [asb_pkg::CmdCondW-1:0] condField = wrData[asb_pkg::CmdCondLsb +: asb_pkg::CmdCondW];
  wire accSel = wrData[asb_pkg::CmdAccSel];
  wire zSel = wrData[asb_pkg::CmdZSel];
  wire extSfr = wrData[asb_pkg::CmdExtSfr];
  wire accPresent = wrData[asb_pkg::CmdAccPresent];
  asb_pkg::asb_op_t op;
  assign op = asb_pkg::asb_op_t'(opField);

  wire carryIn = status_q[asb_pkg::StC];
  wire useCarry = (op == asb_pkg::OpAddCarry) || (op == asb_pkg::OpAddLit10Carry)
                  || (op == asb_pkg::OpAddLit5Carry);
  wire [W-1:0] ten_bit_literal = {{(W-asb_pkg::Lit10W){1'b0}}, opB_q[asb_pkg::Lit10W-1:0]};
  wire [W-1:0] five_bit_literal = {{(W-asb_pkg::Lit5W){1'b0}}, opB_q[asb_pkg::Lit5W-1:0]};
  logic [W-1:0] addB;
  always_comb begin
    case (op)
      asb_pkg::OpAddLit10, asb_pkg::OpAddLit10Carry: addB = ten_bit_literal;
      asb_pkg::OpAddLit5, asb_pkg::OpAddLit5Carry: addB = five_bit_literal;
      default: addB = opB_q;
    endcase
  end

  logic [W-1:0] sum;
  logic cOut, dcOut, vOut;
  asb_adder uAdder (
    .a(opA_q),
    .b(addB),
    .cin(useCarry & carryIn),
    .sum(sum),
    .cout(cOut),
    .dcout(dcOut),
    .ovf(vOut)
  );

  logic condTrue;
  asb_cond_eval uCond (
    .cond(condField),
    .status(status_q),
    .accPresent(accPresent),
    .taken(condTrue)
  );

  // ==========================================
  // shifter and accumulator datapath
  wire [W-1:0] asr1 = {opA_q[W-1], opA_q[W-1:1]};
  wire [asb_pkg::ShAmtW-1:0] shAmt = opB_q[asb_pkg::ShAmtW-1:0];
  wire [W-1:0] asrN = W'($signed(opA_q) >>> shAmt);
  wire signed [asb_pkg::ShiftLitW-1:0] shLit = opB_q[asb_pkg::ShiftLitW-1:0];
  wire signed [AW-1:0] accSrc = AW'($signed(opA_q));
  // positive literal shifts right, negative shifts left
  wire signed [AW-1:0] accShifted = shLit[asb_pkg::ShiftLitW-1]
    ? (accSrc <<< (-shLit)) : (accSrc >>> shLit);
  wire [AW-1:0] accOld = accSel ? accB_q : accA_q;
  wire [AW:0] accSum = {accOld[AW-1], accOld} + {accShifted[AW-1], accShifted};
  wire accOvf = accSum[AW] != accSum[AW-1];
  // overflow beyond the 32-bit word part counts as spilling into the guard bits
  wire accGuard = ~((&accSum[AW-1:W+W-1]) | ~(|accSum[AW-1:W+W-1]));
  wire accSat = accOvf;
  wire [AW-1:0] accRes = accOvf ? {accSum[AW], {(AW-1){~accSum[AW]}}} : accSum[AW-1:0];
  wire [3:0] bitSel = opB_q[3:0];
  wire flagBit = zSel ? status_q[asb_pkg::StZ] : status_q[asb_pkg::StC];

  // ==========================================
  // execute
  always_comb begin
    result_d = result_q;
    status_d = status_q;
    accA_d = accA_q;
    accB_d = accB_q;
    cycles_d = cycles_q;
    taken_d = 1'b0;
    if (cmdWrite) begin
      cycles_d = asb_pkg::CyclesBase;
      case (op)
        asb_pkg::OpAdd, asb_pkg::OpAddCarry, asb_pkg::OpAddLit10, asb_pkg::OpAddLit10Carry,
        asb_pkg::OpAddLit5, asb_pkg::OpAddLit5Carry: begin
          result_d = sum;
          status_d[asb_pkg::StC] = cOut;
          status_d[asb_pkg::StDc] = dcOut;
          status_d[asb_pkg::StN] = sum[W-1];
          status_d[asb_pkg::StOv] = vOut;
          status_d[asb_pkg::StZ] = (sum == '0);
        end
        asb_pkg::OpAccAdd: begin
          if (accSel) begin
            accB_d = accRes;
            status_d[asb_pkg::StOb] = accOvf | accGuard;
            status_d[asb_pkg::StSb] = status_q[asb_pkg::StSb] | accSat;
          end else begin
            accA_d = accRes;
            status_d[asb_pkg::StOa] = accOvf | accGuard;
            status_d[asb_pkg::StSa] = status_q[asb_pkg::StSa] | accSat;
          end
        end
        asb_pkg::OpAsr1: begin
          result_d = asr1;
          status_d[asb_pkg::StC] = opA_q[0];
          status_d[asb_pkg::StN] = asr1[W-1];
          status_d[asb_pkg::StOv] = 1'b0;
          status_d[asb_pkg::StZ] = (asr1 == '0);
        end
        asb_pkg::OpAsrN, asb_pkg::OpAsrLit5: begin
          result_d = asrN;
          status_d[asb_pkg::StN] = asrN[W-1];
          status_d[asb_pkg::StZ] = (asrN == '0);
        end
        asb_pkg::OpBranchCond: begin
          taken_d = condTrue;
          cycles_d = condTrue ? asb_pkg::CyclesTaken : asb_pkg::CyclesBase;
        end
        asb_pkg::OpBranch, asb_pkg::OpBranchComputed: begin
          taken_d = 1'b1;
          cycles_d = asb_pkg::CyclesTaken;
        end
        asb_pkg::OpFlagToBit: begin
          result_d = opA_q;
          result_d[bitSel] = flagBit;
        end
        default: begin
          result_d = result_q;
        end
      endcase
      if (extSfr) begin
        cycles_d = cycles_d + asb_pkg::CyclesSfrExtra;
      end
    end
  end

  // ==========================================
  // cycle sequencer: busy stands for the instruction's cycles after the first
  always_comb begin
    state_d = state_q;
    waitCnt_d = waitCnt_q;
    busy_d = busy_q;
    case (state_q)
      asb_pkg::StIdle: begin
        if (cmdWrite && (cycles_d > asb_pkg::CyclesBase)) begin
          state_d = asb_pkg::StWait;
          waitCnt_d = cycles_d - asb_pkg::CyclesBase;
          busy_d = 1'b1;
        end
      end
      asb_pkg::StWait: begin
        waitCnt_d = waitCnt_q - 3'h1;
        if (waitCnt_q == 3'h1) begin
          state_d = asb_pkg::StIdle;
          busy_d = 1'b0;
        end
      end
      default: begin
        state_d = asb_pkg::StIdle;
        busy_d = 1'b0;
      end
    endcase
  end

  // ==========================================
  // register read mux
  logic [W-1:0] rdMux;
  always_comb begin
    case (addr)
      asb_pkg::RegOpA: rdMux = opA_q;
      asb_pkg::RegOpB: rdMux = opB_q;
      asb_pkg::RegResult: rdMux = result_q;
      asb_pkg::RegStatus: rdMux = {{(W-asb_pkg::StatusW){1'b0}}, status_q};
      asb_pkg::RegAccAL: rdMux = accA_q[W-1:0];
      asb_pkg::RegAccBL: rdMux = accB_q[W-1:0];
      asb_pkg::RegAccAH: rdMux = accA_q[W+W-1:W];
      asb_pkg::RegAccBH: rdMux = accB_q[W+W-1:W];
      asb_pkg::RegCycles: rdMux = {{(W-3){1'b0}}, cycles_q};
      asb_pkg::RegBusy: rdMux = {{(W-1){1'b0}}, busy_q};
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opA_q <= '0;
      opB_q <= '0;
      result_q <= '0;
      status_q <= asb_pkg::StatusReset;
      accA_q <= '0;
      accB_q <= '0;
      cycles_q <= '0;
      waitCnt_q <= '0;
      state_q <= asb_pkg::StIdle;
      busy_q <= 1'b0;
      taken_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      if (wrStrobe && addr == asb_pkg::RegOpA) opA_q <= wrData;
      if (wrStrobe && addr == asb_pkg::RegOpB) opB_q <= wrData;
      result_q <= result_d;
      status_q <= status_d;
      accA_q <= accA_d;
      accB_q <= accB_d;
      cycles_q <= cycles_d;
      waitCnt_q <= waitCnt_d;
      state_q <= state_d;
      busy_q <= busy_d;
      taken_q <= taken_d;
      rdData_q <= rdStrobe ? rdMux : '0;
    end
  end

  assign rdData = rdData_q;
  assign busy = busy_q;
  assign branchTaken = taken_q;
endmodule : asb_exec_unit

//--- test/asb_exec_unit_asserts.sv
`timescale 1ns/1ns
module asb_exec_unit_asserts (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [asb_pkg::AddrW-1:0] addr,
  input wire logic [asb_pkg::DataW-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [asb_pkg::DataW-1:0] rdData,
  input wire logic busy,
  input wire logic branchTaken
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // command acceptance
  // a command written while busy is dropped, so only this one starts work
  wire cmdGo = wrStrobe && addr == asb_pkg::RegCmd && !busy;
  wire [3:0] op = wrData[3:0];
  wire noExt = !wrData[asb_pkg::CmdExtSfr];
  // ==========================================
  // assertions
  a_add_one_cycle: assert property (cmdGo && op <= 4'h5 && noExt |=> !busy && !branchTaken)
    else $error("add took more than one cycle");
  a_acc_one_cycle: assert property (cmdGo && op == 4'h6 && noExt |=> !busy)
    else $error("accumulator add took more than one cycle");
  a_shift_one_cycle: assert property (cmdGo && op inside {4'h7, 4'h8, 4'h9} && noExt |=> !busy)
    else $error("shift took more than one cycle");
  a_uncond_taken: assert property (cmdGo && op inside {4'hB, 4'hC} |=> branchTaken ##1 !branchTaken)
    else $error("unconditional branch not taken as one pulse");
  a_taken_hold: assert property (branchTaken |-> busy [*3])
    else $error("taken branch shorter than four cycles");
  a_taken_cause: assert property (branchTaken |-> $past(cmdGo))
    else $error("branch pulse without a command");
  a_acc_cond_off: assert property (cmdGo && op == 4'hA && wrData[8:4] >= 5'h10 && !wrData[12] |=> !branchTaken)
    else $error("accumulator condition taken without accumulator datapath");
  a_bit_write_quick: assert property (cmdGo && op == 4'hD && noExt |=> !busy && !branchTaken)
    else $error("flag to bit write took more than one cycle");
  a_sfr_extra: assert property (cmdGo && op == 4'hE && !noExt |=> busy ##1 !busy)
    else $error("outer register access did not add exactly one cycle");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:4] !busy)
    else $error("busy longer than the longest instruction");
  c_taken: cover property (branchTaken);
  c_long: cover property ($rose(busy) ##4 !busy);
  c_read: cover property (rdStrobe ##1 rdData != '0);
endmodule : asb_exec_unit_asserts

bind asb_exec_unit asb_exec_unit_asserts chk (.clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .busy(busy), .branchTaken(branchTaken));

//--- test/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clock;
  logic arst_n;
  logic [3:0] addr;
  logic [15:0] wrData;
  logic wrStrobe;
  logic rdStrobe;
  logic [15:0] rdData;
  logic busy;
  logic branchTaken;
  logic tk;
  logic t;
  logic [8:0] st;
  logic [15:0] ex;
  logic [15:0] bb;
  logic [15:0] av [3] = '{16'h8FF9, 16'h7FFF, 16'hFFFF};
  logic [15:0] bv [3] = '{16'hF02F, 16'h0001, 16'h0001};
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int i;
  asb_exec_unit uut (.clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .busy(busy), .branchTaken(branchTaken));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ==========================================
  // bus tasks
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    #1;
    tk = branchTaken;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1;
    `CHK(nm, e, rdData)
  endtask : rdc
  task ops(input logic [15:0] a, input logic [15:0] b);
    wr(asb_pkg::RegOpA, a);
    wr(asb_pkg::RegOpB, b);
  endtask : ops
  // busy is counted at the ports, the cycle register is read back as well
  task exec(input logic [15:0] c, input logic et, input int ec);
    wr(asb_pkg::RegCmd, c);
    `CHK("taken", et, tk)
    n = 1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("cycles", ec, n)
    `CHK("busyLow", 1'b0, busy)
    rdc(asb_pkg::RegCycles, 16'(ec), "cycleReg");
  endtask : exec
  task results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // ==========================================
  // expected flags
  function automatic logic [15:0] addm(input logic [15:0] a, input logic [15:0] b, input logic ci);
    logic [16:0] s;
    logic [4:0] lo;
    s = {1'b0, a} + {1'b0, b} + 17'(ci);
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    st[asb_pkg::StC] = s[16];
    st[asb_pkg::StDc] = lo[4];
    st[asb_pkg::StOv] = (a[15] == b[15]) && (s[15] != a[15]);
    return s[15:0];
  endfunction : addm
  function automatic logic condm(input int k);
    logic c;
    logic z;
    logic v;
    logic ng;
    c = st[asb_pkg::StC];
    z = st[asb_pkg::StZ];
    v = st[asb_pkg::StOv];
    ng = st[asb_pkg::StN];
    case (k)
      0: return c;
      1: return !c;
      2: return ng;
      3: return !ng;
      4: return v;
      5: return !v;
      6: return z;
      7: return !z;
      8: return !z && (ng == v);
      9: return ng == v;
      10: return ng != v;
      11: return z || (ng != v);
      12: return c && !z;
      13: return c;
      14: return !c;
      15: return !c || z;
      default: return st[asb_pkg::StOa + k - 16];
    endcase
  endfunction : condm
  // ==========================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wrData = 16'h0000;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    st = asb_pkg::StatusReset;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rdc(asb_pkg::RegStatus, 16'h0000, "statusReset");
    for (int p = 0; p < 3; p++) begin
      // shifts first, then all six add forms, so branches meet fresh add flags
      for (int j = 0; j < 9; j++) begin
        i = (j + 7) % 10;
        ops(av[p], bv[p]);
        bb = (i < 2) ? bv[p] : (i < 4) ? {6'h00, bv[p][9:0]} : {11'h000, bv[p][4:0]};
        case (i)
          7: begin
            ex = {av[p][15], av[p][15:1]};
            st[asb_pkg::StC] = av[p][0];
            st[asb_pkg::StOv] = 1'b0;
          end
          8, 9: ex = 16'($signed(av[p]) >>> bv[p][3:0]);
          default: ex = addm(av[p], bb, (i % 2 == 1) ? st[asb_pkg::StC] : 1'b0);
        endcase
        st[asb_pkg::StN] = ex[15];
        st[asb_pkg::StZ] = (ex == 16'h0000);
        exec({12'h000, 4'(i)}, 1'b0, 1);
        rdc(asb_pkg::RegResult, ex, "result");
        rdc(asb_pkg::RegStatus, {7'h00, st}, "status");
      end
      for (int k = 0; k < 20; k++) begin
        t = condm(k);
        exec({3'h0, 1'b1, 3'h0, 5'(k), 4'hA}, t, t ? 4 : 1);
      end
      rdc(asb_pkg::RegStatus, {7'h00, st}, "branchStatus");
    end
    ops(16'h0010, 16'h0000);
    exec(16'h1006, 1'b0, 1);
    ops(16'hFFF0, 16'h0001);
    exec(16'h1206, 1'b0, 1);
    rdc(asb_pkg::RegAccAL, 16'h0010, "accAL");
    rdc(asb_pkg::RegAccBL, 16'hFFF8, "accBL");
    rdc(asb_pkg::RegAccBH, 16'hFFFF, "accBH");
    rdc(asb_pkg::RegStatus, {7'h00, st}, "accStatus");
    // walk accumulator A into its guard bits so the overflow tests meet a set flag
    ops(16'h7FFF, 16'h0008);
    for (int k = 0; k < 257; k++) exec(16'h1006, 1'b0, 1);
    st[asb_pkg::StOa] = 1'b1;
    rdc(asb_pkg::RegStatus, {7'h00, st}, "accGuard");
    rdc(asb_pkg::RegAccAH, 16'h807E, "accAH");
    rdc(asb_pkg::RegAccAL, 16'hFF10, "accALGuard");
    exec(16'h110A, 1'b1, 4);
    for (int z = 0; z < 2; z++) begin
      ops(16'h5A5A, (z == 1) ? 16'h0004 : 16'h0002);
      ex = 16'h5A5A;
      ex[(z == 1) ? 4 : 2] = (z == 1) ? st[asb_pkg::StZ] : st[asb_pkg::StC];
      exec({5'h00, 1'(z), 6'h00, 4'hD}, 1'b0, 1);
      rdc(asb_pkg::RegResult, ex, "bitWrite");
      rdc(asb_pkg::RegStatus, {7'h00, st}, "bitStatus");
    end
    exec(16'h010A, 1'b0, 1);
    exec(16'h080E, 1'b0, 2);
    exec(16'h000B, 1'b1, 4);
    exec(16'h000C, 1'b1, 4);
    exec(16'h080B, 1'b1, 5);
    // an add written while the branch still runs must be dropped
    ops(16'h0001, 16'h0001);
    wr(asb_pkg::RegCmd, 16'h000B);
    wr(asb_pkg::RegCmd, 16'h0000);
    repeat (4) @(posedge clock);
    rdc(asb_pkg::RegStatus, {7'h00, st}, "dropped");
    rdc(4'hF, 16'h0000, "unmapped");
    results();
  end
endmodule : testbench
